// *** inc/rtc_cfg.svh ***
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register addresses on the serial link
`define ADDR_SEC        4'h0
`define ADDR_MIN        4'h1
`define ADDR_HOUR       4'h2
`define ADDR_WDAY       4'h3
`define ADDR_DAY        4'h4
`define ADDR_MON        4'h5
`define ADDR_YEAR       4'h6
`define ADDR_WALM_MIN   4'h8
`define ADDR_WALM_HOUR  4'h9
`define ADDR_WALM_DAYS  4'hA
`define ADDR_DALM_MIN   4'hB
`define ADDR_DALM_HOUR  4'hC
`define ADDR_CTRL1      4'hE
`define ADDR_CTRL2      4'hF

// Field masks and positions
`define MASK_SEC        8'h7F
`define MASK_MIN        8'h7F
`define MASK_HOUR       8'h3F
`define MASK_WDAY       8'h07
`define MASK_DAY        8'h3F
`define MASK_MON        8'h1F
`define MASK_DAYS       8'h7F
`define MON_CENT_BIT    7
`define CTRL1_WEN_BIT   7
`define CTRL1_DEN_BIT   6
`define CTRL2_WFLG_BIT  1
`define CTRL2_DFLG_BIT  0
`define FRAME_RD_BIT    3

// Reset values
`define RST_SEC         8'h00
`define RST_MIN         8'h00
`define RST_HOUR        8'h00
`define RST_WDAY        8'h00
`define RST_DAY         8'h01
`define RST_MON         8'h01
`define RST_YEAR        8'h00
`define RST_ALM         8'h00

// Calendar limits in BCD
`define LAST_SEC        8'h59
`define LAST_MIN        8'h59
`define LAST_HOUR       8'h23
`define LAST_WDAY       8'h06
`define LAST_MON        8'h12
`define LAST_YEAR       8'h99

// Timing
`define SEC_PERIOD_NS   1000000000
`define MCLK_PERIOD_NS  25
`define SEC_CYCLES      (`SEC_PERIOD_NS / `MCLK_PERIOD_NS)

`endif

// *** inc/rtc_types_pkg.sv ***
`default_nettype none

package rtc_types_pkg;

	typedef enum logic [1:0] {
		LINK_ADDR  = 2'b00,
		LINK_WRITE = 2'b01,
		LINK_READ  = 2'b10
	} link_state_type;

	typedef logic [7:0] bcd_type;

endpackage

`default_nettype wire

// *** src/serial_link.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module serial_link
	import rtc_types_pkg::*;
(
	// Link pins
	input  wire logic         sclk,
	input  wire logic         ce,
	input  wire logic         reset,
	input  wire logic         serial_data_io_i,
	output logic              serial_data_io_o,
	output logic              serial_data_io_oe,
	// Frozen register image from the core
	input  wire logic [127:0] snap,
	// Write word toward the core
	output logic [3:0]        wr_addr,
	output logic [7:0]        wr_data,
	output logic              wr_tgl
);

	link_state_type state_r;
	logic [2:0]     bit_cnt_r;
	logic [6:0]     shift_r;
	logic [3:0]     addr_r;
	logic [7:0]     byte_in;

	assign byte_in = {shift_r, serial_data_io_i};

	// Chip enable low clears the frame at once
	always_ff @(posedge sclk or negedge ce) begin
		if (!ce) begin
			state_r   <= LINK_ADDR;
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
			addr_r    <= 4'h0;
		end else begin
			shift_r   <= byte_in[6:0];
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				unique case (state_r)
					LINK_ADDR: begin
						addr_r  <= byte_in[7:4];
						state_r <= byte_in[`FRAME_RD_BIT] ? LINK_READ : LINK_WRITE;
					end
					LINK_WRITE, LINK_READ: begin
						addr_r <= addr_r + 4'h1;
					end
				endcase
			end
		end
	end

	// Only whole bytes leave; a cut byte never toggles
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			wr_addr <= 4'h0;
			wr_data <= 8'h00;
			wr_tgl  <= 1'b0;
		end else if (ce && state_r == LINK_WRITE && bit_cnt_r == 3'h7) begin
			wr_addr <= addr_r;
			wr_data <= byte_in;
			wr_tgl  <= ~wr_tgl;
		end
	end

	// Read bits change on the falling edge, host samples on the rising one
	always_ff @(negedge sclk or negedge ce) begin
		if (!ce) begin
			serial_data_io_oe <= 1'b0;
			serial_data_io_o  <= 1'b0;
		end else begin
			serial_data_io_oe <= (state_r == LINK_READ);
			serial_data_io_o  <= snap[{addr_r, ~bit_cnt_r}];
		end
	end

endmodule

`default_nettype wire

// *** src/rtc_calendar.sv ***
// Operation
// - Transfers happen only while chip enable high
// - Host reads and writes all time fields
// - Year divisible by four gives February 29, except year 00 with century bit clear
// - Century bit makes 2000 leap through 2099
// - Alarm match raises the interrupt
// - Weekly alarm: minute, hour, weekday set
// - Daily alarm: hour and minute only
// - Both alarms share one interrupt pin
// - Alarm flags readable over the link
// - Serial data moves with host serial clock
// - Open-drain interrupt inactive after reset
// - Counters held in BCD, two-digit year
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_calendar
	import rtc_types_pkg::*;
#(
	parameter int SEC_CYCLES = `SEC_CYCLES
)(
	// System
	input  wire logic mclk,
	input  wire logic reset,
	// Serial link
	input  wire logic sclk,
	input  wire logic ce,
	input  wire logic serial_data_io_i,
	output logic      serial_data_io_o,
	output logic      serial_data_io_oe,
	// Open-drain alarm interrupt
	input  wire logic alarm_irq_n_i,
	output logic      alarm_irq_n_o,
	output logic      alarm_irq_n_oe
);

	bcd_type       sec_r;
	bcd_type       min_r;
	bcd_type       hour_r;
	bcd_type       wday_r;
	bcd_type       day_r;
	bcd_type       mon_r;
	bcd_type       year_r;
	logic          cent_r;
	bcd_type       walm_min_r;
	bcd_type       walm_hour_r;
	bcd_type       walm_days_r;
	bcd_type       dalm_min_r;
	bcd_type       dalm_hour_r;
	logic          wen_r;
	logic          den_r;
	logic          wflag_r;
	logic          dflag_r;
	logic [31:0]   presc_r;
	logic          tick_pend_r;
	logic          ce_s1_r;
	logic          ce_s2_r;
	logic          tgl_s1_r;
	logic          tgl_s2_r;
	logic          tgl_s3_r;
	logic [127:0]  snap_r;
	logic [127:0]  snap_nxt;
	bcd_type       sec_nxt;
	bcd_type       min_nxt;
	bcd_type       hour_nxt;
	bcd_type       wday_nxt;
	bcd_type       day_nxt;
	bcd_type       mon_nxt;
	bcd_type       year_nxt;
	logic          cent_nxt;
	logic [3:0]    link_wr_addr;
	logic [7:0]    link_wr_data;
	logic          link_wr_tgl;
	logic          wr_take;
	logic          tick_do;
	logic          new_minute;
	logic          walm_hit;
	logic          dalm_hit;
	logic          wflag_clr;
	logic          dflag_clr;

	function automatic bcd_type bcd_inc(input bcd_type v);
		if (v[3:0] >= 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Only 1900 is excluded; 2100 never occurs in the two-digit range
	function automatic logic is_leap(input bcd_type y, input logic cent);
		logic by_four;
		by_four = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
			(y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
		is_leap = by_four && !(y == 8'h00 && !cent);
	endfunction

	function automatic bcd_type last_day(input bcd_type m, input bcd_type y, input logic cent);
		unique case (m)
			8'h02: last_day = is_leap(y, cent) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	serial_link u_link (
		.sclk              (sclk),
		.ce                (ce),
		.reset             (reset),
		.serial_data_io_i  (serial_data_io_i),
		.serial_data_io_o  (serial_data_io_o),
		.serial_data_io_oe (serial_data_io_oe),
		.snap              (snap_r),
		.wr_addr           (link_wr_addr),
		.wr_data           (link_wr_data),
		.wr_tgl            (link_wr_tgl)
	);

	// Crossing from the link clock
	always_ff @(posedge mclk) begin
		if (reset) begin
			ce_s1_r  <= 1'b0;
			ce_s2_r  <= 1'b0;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			ce_s1_r  <= ce;
			ce_s2_r  <= ce_s1_r;
			tgl_s1_r <= link_wr_tgl;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	// Address and data stay put until the next whole byte
	assign wr_take = tgl_s2_r ^ tgl_s3_r;

	// One-second prescaler; a tick waits one cycle behind a host write
	always_ff @(posedge mclk) begin
		if (reset) begin
			presc_r     <= 32'h0;
			tick_pend_r <= 1'b0;
		end else begin
			if (tick_do) begin
				tick_pend_r <= 1'b0;
			end
			if (wr_take && link_wr_addr == `ADDR_SEC) begin
				presc_r <= 32'h0;
			end else if (presc_r == 32'(SEC_CYCLES - 1)) begin
				presc_r     <= 32'h0;
				tick_pend_r <= 1'b1;
			end else begin
				presc_r <= presc_r + 32'h1;
			end
		end
	end

	assign tick_do = tick_pend_r && !wr_take;

	// BCD carry chain
	always_comb begin
		sec_nxt  = bcd_inc(sec_r);
		min_nxt  = min_r;
		hour_nxt = hour_r;
		wday_nxt = wday_r;
		day_nxt  = day_r;
		mon_nxt  = mon_r;
		year_nxt = year_r;
		cent_nxt = cent_r;
		if (sec_r >= `LAST_SEC) begin
			sec_nxt = 8'h00;
			min_nxt = bcd_inc(min_r);
			if (min_r >= `LAST_MIN) begin
				min_nxt  = 8'h00;
				hour_nxt = bcd_inc(hour_r);
				if (hour_r >= `LAST_HOUR) begin
					hour_nxt = 8'h00;
					wday_nxt = (wday_r >= `LAST_WDAY) ? 8'h00 : bcd_inc(wday_r);
					day_nxt  = bcd_inc(day_r);
					if (day_r >= last_day(mon_r, year_r, cent_r)) begin
						day_nxt = 8'h01;
						mon_nxt = bcd_inc(mon_r);
						if (mon_r >= `LAST_MON) begin
							mon_nxt  = 8'h01;
							year_nxt = bcd_inc(year_r);
							if (year_r >= `LAST_YEAR) begin
								year_nxt = 8'h00;
								cent_nxt = ~cent_r;
							end
						end
					end
				end
			end
		end
	end

	// Time and calendar counters
	always_ff @(posedge mclk) begin
		if (reset) begin
			sec_r  <= `RST_SEC;
			min_r  <= `RST_MIN;
			hour_r <= `RST_HOUR;
			wday_r <= `RST_WDAY;
			day_r  <= `RST_DAY;
			mon_r  <= `RST_MON;
			year_r <= `RST_YEAR;
			cent_r <= 1'b0;
		end else if (wr_take) begin
			unique case (link_wr_addr)
				`ADDR_SEC:  sec_r  <= link_wr_data & `MASK_SEC;
				`ADDR_MIN:  min_r  <= link_wr_data & `MASK_MIN;
				`ADDR_HOUR: hour_r <= link_wr_data & `MASK_HOUR;
				`ADDR_WDAY: wday_r <= link_wr_data & `MASK_WDAY;
				`ADDR_DAY:  day_r  <= link_wr_data & `MASK_DAY;
				`ADDR_MON: begin
					mon_r  <= link_wr_data & `MASK_MON;
					cent_r <= link_wr_data[`MON_CENT_BIT];
				end
				`ADDR_YEAR: year_r <= link_wr_data;
				default: ;
			endcase
		end else if (tick_do) begin
			sec_r  <= sec_nxt;
			min_r  <= min_nxt;
			hour_r <= hour_nxt;
			wday_r <= wday_nxt;
			day_r  <= day_nxt;
			mon_r  <= mon_nxt;
			year_r <= year_nxt;
			cent_r <= cent_nxt;
		end
	end

	// Alarm settings and enables
	always_ff @(posedge mclk) begin
		if (reset) begin
			walm_min_r  <= `RST_ALM;
			walm_hour_r <= `RST_ALM;
			walm_days_r <= `RST_ALM;
			dalm_min_r  <= `RST_ALM;
			dalm_hour_r <= `RST_ALM;
			wen_r       <= 1'b0;
			den_r       <= 1'b0;
		end else if (wr_take) begin
			unique case (link_wr_addr)
				`ADDR_WALM_MIN:  walm_min_r  <= link_wr_data & `MASK_MIN;
				`ADDR_WALM_HOUR: walm_hour_r <= link_wr_data & `MASK_HOUR;
				`ADDR_WALM_DAYS: walm_days_r <= link_wr_data & `MASK_DAYS;
				`ADDR_DALM_MIN:  dalm_min_r  <= link_wr_data & `MASK_MIN;
				`ADDR_DALM_HOUR: dalm_hour_r <= link_wr_data & `MASK_HOUR;
				`ADDR_CTRL1: begin
					wen_r <= link_wr_data[`CTRL1_WEN_BIT];
					den_r <= link_wr_data[`CTRL1_DEN_BIT];
				end
				default: ;
			endcase
		end
	end

	// Alarms fire once, on entry into the matching minute
	assign new_minute = tick_do && sec_nxt == 8'h00;
	assign walm_hit = new_minute && wen_r && min_nxt == walm_min_r &&
		hour_nxt == walm_hour_r && walm_days_r[wday_nxt[2:0]];
	assign dalm_hit = new_minute && den_r && min_nxt == dalm_min_r &&
		hour_nxt == dalm_hour_r;

	// Writing zero to a flag clears it; writing one leaves it
	assign wflag_clr = wr_take && link_wr_addr == `ADDR_CTRL2 &&
		!link_wr_data[`CTRL2_WFLG_BIT];
	assign dflag_clr = wr_take && link_wr_addr == `ADDR_CTRL2 &&
		!link_wr_data[`CTRL2_DFLG_BIT];

	// A hit in the clearing cycle still sets the flag
	always_ff @(posedge mclk) begin
		if (reset) begin
			wflag_r <= 1'b0;
			dflag_r <= 1'b0;
		end else begin
			if (walm_hit) begin
				wflag_r <= 1'b1;
			end else if (wflag_clr) begin
				wflag_r <= 1'b0;
			end
			if (dalm_hit) begin
				dflag_r <= 1'b1;
			end else if (dflag_clr) begin
				dflag_r <= 1'b0;
			end
		end
	end

	// Pin is pulled low only; the pull-up is off chip
	always_ff @(posedge mclk) begin
		if (reset) begin
			alarm_irq_n_o  <= 1'b0;
			alarm_irq_n_oe <= 1'b0;
		end else begin
			alarm_irq_n_o  <= 1'b0;
			alarm_irq_n_oe <= (wflag_r && wen_r) || (dflag_r && den_r);
		end
	end

	// Register image seen by the link
	always_comb begin
		snap_nxt = 128'h0;
		snap_nxt[{`ADDR_SEC, 3'h0} +: 8]       = sec_r;
		snap_nxt[{`ADDR_MIN, 3'h0} +: 8]       = min_r;
		snap_nxt[{`ADDR_HOUR, 3'h0} +: 8]      = hour_r;
		snap_nxt[{`ADDR_WDAY, 3'h0} +: 8]      = wday_r;
		snap_nxt[{`ADDR_DAY, 3'h0} +: 8]       = day_r;
		snap_nxt[{`ADDR_MON, 3'h0} +: 8]       = mon_r | {cent_r, 7'h00};
		snap_nxt[{`ADDR_YEAR, 3'h0} +: 8]      = year_r;
		snap_nxt[{`ADDR_WALM_MIN, 3'h0} +: 8]  = walm_min_r;
		snap_nxt[{`ADDR_WALM_HOUR, 3'h0} +: 8] = walm_hour_r;
		snap_nxt[{`ADDR_WALM_DAYS, 3'h0} +: 8] = walm_days_r;
		snap_nxt[{`ADDR_DALM_MIN, 3'h0} +: 8]  = dalm_min_r;
		snap_nxt[{`ADDR_DALM_HOUR, 3'h0} +: 8] = dalm_hour_r;
		snap_nxt[{`ADDR_CTRL1, 3'h0} + `CTRL1_WEN_BIT] = wen_r;
		snap_nxt[{`ADDR_CTRL1, 3'h0} + `CTRL1_DEN_BIT] = den_r;
		snap_nxt[{`ADDR_CTRL2, 3'h0} + `CTRL2_WFLG_BIT] = wflag_r;
		snap_nxt[{`ADDR_CTRL2, 3'h0} + `CTRL2_DFLG_BIT] = dflag_r;
	end

	// Frozen for the whole frame: the link reads it with no handshake,
	// and the host sees one coherent time; writes show from the next frame
	always_ff @(posedge mclk) begin
		if (reset) begin
			snap_r <= 128'h0;
		end else if (!ce_s2_r) begin
			snap_r <= snap_nxt;
		end
	end

endmodule

`default_nettype wire

// *** testbench/rtc_calendar_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module rtc_calendar_sva #(
	parameter int SEC_CYCLES = 20
)(
	// System
	input wire logic mclk,
	input wire logic reset,
	// Serial link
	input wire logic sclk,
	input wire logic ce,
	input wire logic serial_data_io_i,
	input wire logic serial_data_io_o,
	input wire logic serial_data_io_oe,
	// Interrupt pin
	input wire logic alarm_irq_n_i,
	input wire logic alarm_irq_n_o,
	input wire logic alarm_irq_n_oe
);
	logic [3:0] bit_cnt_r;
	logic       rd_r;
	logic [5:0] gap_r;

	// Cleared by ce like the link, so no stale count
	always_ff @(posedge sclk or negedge ce) begin
		if (!ce)
			bit_cnt_r <= 4'h0;
		else if (bit_cnt_r != 4'hF)
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end

	always_ff @(posedge sclk or negedge ce) begin
		if (!ce)
			rd_r <= 1'b0;
		else if (bit_cnt_r == 4'h4)
			rd_r <= serial_data_io_i;
	end

	// Cycles since chip enable went low
	always_ff @(posedge mclk) begin
		if (reset || ce)
			gap_r <= 6'h00;
		else if (gap_r != 6'h3F)
			gap_r <= gap_r + 6'h01;
	end

	sequence read_hdr;
		bit_cnt_r == 4'h8 && rd_r;
	endsequence

	sequence write_body;
		bit_cnt_r >= 4'h5 && !rd_r;
	endsequence

	chk_read_drives: assert property (@(posedge sclk) disable iff (reset || !ce)
		read_hdr |-> serial_data_io_oe) else $error("read bit not driven");
	chk_write_quiet: assert property (@(posedge sclk) disable iff (reset || !ce)
		write_body |-> !serial_data_io_oe) else $error("line driven in write");
	chk_no_early_oe: assert property (@(posedge sclk) disable iff (reset || !ce)
		serial_data_io_oe |-> bit_cnt_r >= 4'h8) else $error("line driven in header");
	chk_oe_needs_ce: assert property (@(posedge mclk) disable iff (reset)
		!ce |-> !serial_data_io_oe) else $error("line driven without ce");
	chk_oe_stays_up: assert property (@(posedge mclk) disable iff (reset)
		serial_data_io_oe ##1 ce |-> serial_data_io_oe) else $error("read drive dropped");
	chk_irq_od_low: assert property (@(posedge mclk) disable iff (reset)
		alarm_irq_n_o == 1'b0) else $error("interrupt pin driven high");
	chk_irq_reset_idle: assert property (@(posedge mclk) disable iff (reset)
		$fell(reset) |-> !alarm_irq_n_oe) else $error("interrupt active after reset");
	chk_irq_holds: assert property (@(posedge mclk) disable iff (reset)
		$fell(alarm_irq_n_oe) |-> gap_r < 6'h0C) else $error("interrupt dropped by itself");
endmodule

bind rtc_calendar rtc_calendar_sva #(.SEC_CYCLES(SEC_CYCLES)) rtc_calendar_sva_i (
	.mclk(mclk),
	.reset(reset),
	.sclk(sclk),
	.ce(ce),
	.serial_data_io_i(serial_data_io_i),
	.serial_data_io_o(serial_data_io_o),
	.serial_data_io_oe(serial_data_io_oe),
	.alarm_irq_n_i(alarm_irq_n_i),
	.alarm_irq_n_o(alarm_irq_n_o),
	.alarm_irq_n_oe(alarm_irq_n_oe)
);

`default_nettype wire

// *** testbench/host_link.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_link (
	// Link pins
	output logic      sclk,
	output logic      ce,
	output logic      serial_data_io,
	// Device side of the data line
	input  wire logic serial_data_io_o,
	input  wire logic serial_data_io_oe
);
	logic [7:0] wbuf [16];
	logic [7:0] rbuf [16];
	logic       hen;
	logic       hd;

	// No pull on the line: released shows the inverse
	assign serial_data_io = serial_data_io_oe ? serial_data_io_o : (hen ? hd : ~hd);

	initial begin
		sclk = 1'b0;
		ce = 1'b0;
		hen = 1'b0;
		hd = 1'b0;
	end

	// Short nb cuts the frame mid-byte
	task automatic xfer(input logic [3:0] a, input logic rd, input int nb);
		logic [7:0] hdr;
		hdr = {a, rd, 3'h0};
		ce = 1'b1;
		hen = 1'b1;
		#100;
		for (int i = 0; i < 8 + nb; i++) begin
			sclk = 1'b0;
			if (i < 8)
				hd = hdr[7 - i];
			else if (!rd)
				hd = wbuf[(i - 8) / 8][7 - (i % 8)];
			else
				hen = 1'b0;
			#24;
			sclk = 1'b1;
			if (rd && i >= 8)
				rbuf[(i - 8) / 8][7 - (i % 8)] = serial_data_io;
			#24;
		end
		sclk = 1'b0;
		#24;
		ce = 1'b0;
		hen = 1'b0;
		#200;
	endtask
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int SEC_N = 2000;
	logic      mclk;
	logic      reset;
	wire logic sclk;
	wire logic ce;
	wire logic serial_data_io;
	wire logic serial_data_io_o;
	wire logic serial_data_io_oe;
	wire logic irq_o;
	wire logic irq_oe;
	wire logic irq_n;
	int        error_cnt;
	int        checked;

	// Pulled-up open-drain line
	assign irq_n = irq_oe ? irq_o : 1'b1;

	rtc_calendar #(.SEC_CYCLES(SEC_N)) rtc_calendar_i (
		.mclk(mclk),
		.reset(reset),
		.sclk(sclk),
		.ce(ce),
		.serial_data_io_i(serial_data_io),
		.serial_data_io_o(serial_data_io_o),
		.serial_data_io_oe(serial_data_io_oe),
		.alarm_irq_n_i(irq_n),
		.alarm_irq_n_o(irq_o),
		.alarm_irq_n_oe(irq_oe)
	);

	host_link host_link_i (
		.sclk(sclk),
		.ce(ce),
		.serial_data_io(serial_data_io),
		.serial_data_io_o(serial_data_io_o),
		.serial_data_io_oe(serial_data_io_oe)
	);

	always #12.5 mclk = ~mclk;

	task automatic end_sim;
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [63:0] v, input int n);
		for (int k = 0; k < n; k++)
			host_link_i.wbuf[k] = v[63 - 8 * k -: 8];
		host_link_i.xfer(a, 1'b0, 8 * n);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [63:0] v, input int n);
		host_link_i.xfer(a, 1'b1, 8 * n);
		for (int k = 0; k < n; k++)
			cmp($sformatf("reg %h", a + k), v[63 - 8 * k -: 8], host_link_i.rbuf[k]);
	endtask

	task automatic t_reset;
		rchk(4'h0, 64'h0000_0000_0101_0000, 7);
		cmp("irq_n", 8'h01, {7'h00, irq_n});
	endtask

	// Each row: day, month, year written, then expected after one tick
	task automatic t_calendar;
		logic [47:0] rows [5];
		rows = '{48'h28_02_04_29_02_04, 48'h28_02_01_01_03_01, 48'h28_02_00_01_03_00,
			48'h28_82_00_29_82_00, 48'h31_12_99_01_81_00};
		for (int r = 0; r < 5; r++) begin
			wr(4'h0, {24'h59_59_23, 8'h06, rows[r][47:24], 8'h00}, 7);
			repeat (SEC_N + 200) @(posedge mclk);
			rchk(4'h0, {32'h0, rows[r][23:0], 8'h00}, 7);
		end
	endtask

	task automatic almstep(input logic [7:0] wd, input logic [7:0] mn, input logic [7:0] fl);
		wr(4'h0, {8'h59, mn, 8'h10, wd, 32'h0}, 4);
		repeat (SEC_N + 200) @(posedge mclk);
		rchk(4'hF, {fl, 56'h0}, 1);
		cmp("irq_n", {7'h00, fl == 8'h00}, {7'h00, irq_n});
	endtask

	task automatic t_alarm;
		wr(4'h8, 64'h30_10_28_31_10_00_C0_00, 7);
		rchk(4'hB, {24'h31_10_00, 40'h0}, 3);
		almstep(8'h02, 8'h29, 8'h00);
		almstep(8'h05, 8'h29, 8'h02);
		wr(4'hF, 64'h0, 1);
		rchk(4'hF, 64'h0, 1);
		cmp("irq_n", 8'h01, {7'h00, irq_n});
		almstep(8'h05, 8'h30, 8'h01);
		// Writing ones must leave a pending flag alone
		wr(4'hF, {8'h03, 56'h0}, 1);
		rchk(4'hF, {8'h01, 56'h0}, 1);
		cmp("irq_n", 8'h00, {7'h00, irq_n});
	endtask

	// Cut write and cut read must leave no trace
	task automatic t_abort;
		host_link_i.wbuf[0] = 8'hFF;
		host_link_i.xfer(4'hB, 1'b0, 5);
		host_link_i.xfer(4'hB, 1'b1, 4);
		rchk(4'hB, {8'h31, 56'h0}, 1);
		cmp("serial_data_io_oe", 8'h00, {7'h00, serial_data_io_oe});
	endtask

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		error_cnt = 0;
		checked = 0;
		repeat (6) @(posedge mclk);
		#2 reset = 1'b0;
		repeat (3) @(posedge mclk);
		#2;
		t_reset;
		t_calendar;
		t_alarm;
		t_abort;
		end_sim;
	end

	initial begin
		#2000000;
		error_cnt++;
		end_sim;
	end
endmodule

`default_nettype wire
